/* File: logic/asr_pkg.sv */
// Package for the host-side controller of a 4096 x 4 asynchronous static RAM.
// Assumes a 100 MHz ref_clk; pin timings are held here in ns and rounded to clock counts by asr_cyc_up.
`default_nettype none

package asr_pkg;

  // ----------------------------------------------------------------------------
  // Array shape
  // ----------------------------------------------------------------------------
  localparam int ASR_ADDR_W = 12;
  localparam int ASR_DATA_W = 4;
  localparam int ASR_WORDS  = 4096;

  // ----------------------------------------------------------------------------
  // Clock and speed grades
  // ----------------------------------------------------------------------------
  localparam int ASR_CLK_PERIOD_PS = 10000;
  localparam int ASR_GRADES        = 3;

  // Speed grade selector values.
  typedef enum logic [1:0] {
    ASR_GRADE_FAST,
    ASR_GRADE_MID,
    ASR_GRADE_SLOW
  } asr_grade_t;

  // Pin timings in ns, one entry per grade, fast grade first.
  localparam int ASR_T_READ_CYC_NS [ASR_GRADES] = '{20, 25, 35};
  localparam int ASR_T_CE_ACC_NS   [ASR_GRADES] = '{20, 25, 35};
  localparam int ASR_T_OE_ACC_NS   [ASR_GRADES] = '{10, 12, 14};
  localparam int ASR_T_RELEASE_NS  [ASR_GRADES] = '{8, 10, 15};
  localparam int ASR_T_WRITE_CYC_NS[ASR_GRADES] = '{20, 25, 35};
  localparam int ASR_T_WR_PULSE_NS [ASR_GRADES] = '{15, 20, 25};
  localparam int ASR_T_ADDR_WR_NS  [ASR_GRADES] = '{15, 20, 30};
  localparam int ASR_T_DATA_WR_NS  [ASR_GRADES] = '{10, 10, 15};
  localparam int ASR_T_CE_WR_NS    [ASR_GRADES] = '{15, 20, 30};

  // Least-time rounding up to whole cycles, never below one.
  function automatic int asr_cyc_up(input int ns);
    int c;
    c = (ns * 1000 + ASR_CLK_PERIOD_PS - 1) / ASR_CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ASR_CNT_W = 4;

endpackage

`default_nettype wire

/* File: logic/asr_timing_if.sv */
// Interface carrying the per-grade cycle counts from the timing table to the controller.
// Assumes both ends share ref_clk; the counts are static per grade.
`timescale 1ns/1ps
`default_nettype none

interface asr_timing_if;
  import asr_pkg::*;

  logic [ASR_CNT_W-1:0] rd_cycles;
  logic [ASR_CNT_W-1:0] oe_release;
  logic [ASR_CNT_W-1:0] wr_pulse;
  logic [ASR_CNT_W-1:0] wr_cycles;

  modport table_side (output rd_cycles, output oe_release, output wr_pulse, output wr_cycles);
  modport ctrl_side  (input rd_cycles, input oe_release, input wr_pulse, input wr_cycles);
endinterface

`default_nettype wire

/* File: logic/asr_timing_table.sv */
// Converts the selected speed grade into cycle counts for the access controller.
// Assumes grade changes only while the controller is idle.
`timescale 1ns/1ps
`default_nettype none

module asr_timing_table
  import asr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire asr_grade_t grade,
  asr_timing_if.table_side tim
);

  // ----------------------------------------------------------------------------
  // Count lookup
  // ----------------------------------------------------------------------------

  // Read slot covers the cycle time and the enable access time together.
  function automatic logic [ASR_CNT_W-1:0] grade_count(input int ns_a, input int ns_b);
    int m;
    m = (ns_a > ns_b) ? ns_a : ns_b;
    return ASR_CNT_W'(asr_cyc_up(m));
  endfunction

  // Counts are registered so that each grade change settles cleanly.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tim.rd_cycles  <= ASR_CNT_W'(asr_cyc_up(ASR_T_CE_ACC_NS[2]));
      tim.oe_release <= ASR_CNT_W'(asr_cyc_up(ASR_T_RELEASE_NS[2]));
      tim.wr_pulse   <= ASR_CNT_W'(asr_cyc_up(ASR_T_CE_WR_NS[2]));
      tim.wr_cycles  <= ASR_CNT_W'(asr_cyc_up(ASR_T_WRITE_CYC_NS[2]));
    end
    else
    begin
      // Read covers cycle time and enable access.
      tim.rd_cycles  <= grade_count(ASR_T_READ_CYC_NS[grade], ASR_T_CE_ACC_NS[grade]);
      tim.oe_release <= grade_count(ASR_T_RELEASE_NS[grade], ASR_T_RELEASE_NS[grade]);
      // Strobe covers pulse, address and enable minima.
      tim.wr_pulse   <= grade_count(grade_count(ASR_T_WR_PULSE_NS[grade], ASR_T_ADDR_WR_NS[grade])
                                    * (ASR_CLK_PERIOD_PS / 1000),
                                    ASR_T_CE_WR_NS[grade]);
      tim.wr_cycles  <= grade_count(ASR_T_WRITE_CYC_NS[grade], ASR_T_DATA_WR_NS[grade]);
    end
  end

endmodule

`default_nettype wire

/* File: logic/asr_host_ctrl.sv */
// Host controller that drives a 4096 x 4 asynchronous static RAM through its pins.
// Assumes the RAM's pins are wired straight to these ports and ref_clk is 100 MHz.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Write enable held high throughout every read.
// - Read cycle lasts at least the grade minimum.
// - Write cycle and strobe width meet grade minimum.
// - Address stable long enough before write ends.
// - Write data valid long enough before end.
// - Chip enable low long enough before end.
// - Address valid no later than enable falling.
module asr_host_ctrl
  import asr_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire asr_grade_t            grade,
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic [ASR_ADDR_W-1:0] req_addr,
  input  wire logic [ASR_DATA_W-1:0] req_wdata,
  output logic                       req_ready,
  output logic                       rsp_valid,
  output logic [ASR_DATA_W-1:0]      rsp_rdata,
  output logic [ASR_ADDR_W-1:0]      word_address_lines,
  output logic                       chip_enable_n,
  output logic                       output_enable_n,
  output logic                       write_enable_n,
  input  wire logic [ASR_DATA_W-1:0] data_in,
  output logic [ASR_DATA_W-1:0]      data_out,
  output logic                       data_oe
);

  // ----------------------------------------------------------------------------
  // Timing table
  // ----------------------------------------------------------------------------
  asr_timing_if tim ();

  asr_timing_table u_table (
    .ref_clk (ref_clk),
    .reset   (reset),
    .grade   (grade),
    .tim     (tim)
  );

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ASR_IDLE,
    ASR_READ,
    ASR_RD_REL,
    ASR_WR_SETUP,
    ASR_WRITE,
    ASR_WR_END
  } asr_state_t;

  asr_state_t           state;
  logic [ASR_CNT_W-1:0] count;

  // State walk: read, release and write phases wait their counted cycles before moving on.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state <= ASR_IDLE;
      count <= '0;
    end
    else
    begin
      case (state)
        ASR_IDLE:
        begin
          count <= '0;
          if (req_valid)
          begin
            state <= req_write ? ASR_WR_SETUP : ASR_READ;
          end
        end
        ASR_READ:
        begin
          // Hold enables until cycle time and access time have both passed.
          if (count >= tim.rd_cycles - ASR_CNT_W'(1))
          begin
            state <= ASR_RD_REL;
            count <= '0;
          end
          else
          begin
            count <= count + ASR_CNT_W'(1);
          end
        end
        ASR_RD_REL:
        begin
          // Give the RAM its release time before our own drivers turn on.
          if (count >= tim.oe_release - ASR_CNT_W'(1))
          begin
            state <= ASR_IDLE;
          end
          count <= count + ASR_CNT_W'(1);
        end
        ASR_WR_SETUP:
        begin
          state <= ASR_WRITE;
        end
        ASR_WRITE:
        begin
          // Strobe low long enough for pulse, address and enable minima.
          if (count >= tim.wr_pulse - ASR_CNT_W'(1))
          begin
            state <= ASR_WR_END;
            count <= '0;
          end
          else
          begin
            count <= count + ASR_CNT_W'(1);
          end
        end
        default:
        begin
          state <= ASR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------------

  // Address and write data are latched when a request is taken and held to the end.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      word_address_lines <= '0;
      data_out           <= '0;
    end
    else if (state == ASR_IDLE && req_valid)
    begin
      word_address_lines <= req_addr; // Address set in the same edge as enable falls.
      data_out           <= req_wdata;
    end
  end

  // Strobes: chip enable falls with the access; output enable only on reads.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      chip_enable_n   <= 1'b1; // Deselected RAM floats its pins.
      output_enable_n <= 1'b1;
      write_enable_n  <= 1'b1;
      data_oe         <= 1'b0;
    end
    else
    begin
      // Select rises in the same edge as the write strobe, so the RAM never drives after a write.
      chip_enable_n   <= !(state == ASR_IDLE && req_valid)
                         && !(state == ASR_READ && count < tim.rd_cycles - ASR_CNT_W'(1))
                         && !(state == ASR_WR_SETUP)
                         && !(state == ASR_WRITE && count < tim.wr_pulse - ASR_CNT_W'(1));
      // Output enable only during reads, so a write never sees RAM drive.
      output_enable_n <= !(state == ASR_IDLE && req_valid && !req_write)
                         && !(state == ASR_READ && count < tim.rd_cycles - ASR_CNT_W'(1));
      // Write strobe falls with chip enable already low and rises with it.
      write_enable_n  <= !(state == ASR_WR_SETUP) && !(state == ASR_WRITE && count < tim.wr_pulse - ASR_CNT_W'(1));
      // Drive data only across the write, with zero hold after the end.
      data_oe         <= (state == ASR_IDLE && req_valid && req_write) || state == ASR_WR_SETUP
                         || (state == ASR_WRITE && count < tim.wr_pulse - ASR_CNT_W'(1));
    end
  end

  // ----------------------------------------------------------------------------
  // Request and answer
  // ----------------------------------------------------------------------------

  // Read data captured in the last enabled read cycle; ready only while idle.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      req_ready <= 1'b0;
    end
    else
    begin
      rsp_valid <= (state == ASR_READ && count >= tim.rd_cycles - ASR_CNT_W'(1));
      if (state == ASR_READ && count >= tim.rd_cycles - ASR_CNT_W'(1))
      begin
        rsp_rdata <= data_in; // Sampled after access time, before release.
      end
      req_ready <= (state == ASR_IDLE && !req_valid)
                   || (state == ASR_RD_REL && count >= tim.oe_release - ASR_CNT_W'(1))
                   || state == ASR_WR_END;
    end
  end

endmodule

`default_nettype wire

/* File: dv/asr_host_ctrl_assertions.sv */
// Checker for the RAM pin sequencing of the host controller.
// Assumes it is bound to asr_host_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module asr_chk
  import asr_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire asr_grade_t            grade,
  input wire logic                  rsp_valid,
  input wire logic [ASR_ADDR_W-1:0] word_address_lines,
  input wire logic                  chip_enable_n,
  input wire logic                  output_enable_n,
  input wire logic                  write_enable_n,
  input wire logic [ASR_DATA_W-1:0] data_out,
  input wire logic                  data_oe
);
  // ---------------------------------------------------------------------------
  // Strobe relations
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_read_we_high: assert property (!output_enable_n |-> write_enable_n && !data_oe && !chip_enable_n)
    else $error("write strobe or host drive during read");
  a_we_in_ce: assert property (!write_enable_n |-> !chip_enable_n && data_oe && output_enable_n)
    else $error("write strobe outside select");
  a_addr_held: assert property (!chip_enable_n && !$fell(chip_enable_n) |-> $stable(word_address_lines))
    else $error("address moved during access");
  a_data_held: assert property (!write_enable_n |-> $stable(data_out))
    else $error("write data moved during strobe");
  a_ce_first: assert property ($fell(write_enable_n) |-> !$past(chip_enable_n))
    else $error("select not ahead of write strobe");
  a_wr_pulse: assert property ($fell(write_enable_n) && grade != ASR_GRADE_SLOW |->
    !write_enable_n [*2] ##1 write_enable_n)
    else $error("write pulse length wrong");
  a_wr_pulse_slow: assert property ($fell(write_enable_n) && grade == ASR_GRADE_SLOW |->
    !write_enable_n [*3] ##1 write_enable_n)
    else $error("slow write pulse length wrong");
  a_end_together: assert property ($rose(write_enable_n) |-> $rose(chip_enable_n) && !data_oe)
    else $error("write end not coincident");
  a_rd_len_fast: assert property ($fell(output_enable_n) && grade == ASR_GRADE_FAST |->
    !output_enable_n [*2] ##1 rsp_valid)
    else $error("fast read length wrong");
  a_rd_len_slow: assert property ($fell(output_enable_n) && grade == ASR_GRADE_SLOW |->
    !output_enable_n [*4] ##1 rsp_valid)
    else $error("slow read length wrong");
  a_release_gap: assert property ($rose(output_enable_n) |=> chip_enable_n)
    else $error("no release gap after read");
  // Main scenarios.
  c_read: cover property ($rose(rsp_valid));
  c_write: cover property ($rose(write_enable_n));
  c_slow: cover property (grade == ASR_GRADE_SLOW && !write_enable_n);
endmodule
bind asr_host_ctrl asr_chk u_chk (.ref_clk, .reset, .grade, .rsp_valid, .word_address_lines, .chip_enable_n,
  .output_enable_n, .write_enable_n, .data_out, .data_oe);
`default_nettype wire

/* File: dv/asr_sram_model.sv */
// Behavioural 4096 x 4 static RAM on the far side of the controller.
// Assumes the bench resolves the shared data pins from both drivers.
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model
  import asr_pkg::*;
#(parameter int ACC_NS = 8)
(
  input  wire logic [ASR_ADDR_W-1:0] addr,
  input  wire logic                  ce_n,
  input  wire logic                  oe_n,
  input  wire logic                  we_n,
  input  wire logic [ASR_DATA_W-1:0] bus,
  output logic [ASR_DATA_W-1:0]      q
);
  logic [ASR_DATA_W-1:0] mem [ASR_WORDS];
  logic [ASR_DATA_W-1:0] last;
  logic                  drive;
  // Drives real data only in a selected read; either enable high gives the inverse of the last word.
  assign drive = !ce_n && !oe_n && we_n;
  // Stores during the overlap of both enables low.
  always @* if (!ce_n && !we_n) mem[addr] = bus;
  // Remembers the last driven word so a released pin shows its inverse.
  always @* if (drive) last = mem[addr];
  // Data appears within access time and is released as quickly.
  assign #(ACC_NS) q = drive ? mem[addr] : ~last;
endmodule
`default_nettype wire

/* File: dv/test_asr_host_ctrl.sv */
// Testbench for the host controller against a behavioural RAM.
// Assumes a 100 MHz clock; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module test_asr_host_ctrl;
  import asr_pkg::*;
  logic                  ref_clk = 0;
  logic                  reset = 1;
  logic                  req_valid = 0;
  logic                  req_write = 0;
  asr_grade_t            grade = ASR_GRADE_FAST;
  logic [ASR_ADDR_W-1:0] req_addr = '0;
  logic [ASR_ADDR_W-1:0] word_address_lines;
  logic [ASR_DATA_W-1:0] req_wdata = '0;
  logic [ASR_DATA_W-1:0] rsp_rdata, data_in, data_out, ram_q, rd;
  logic                  req_ready, rsp_valid, chip_enable_n, output_enable_n, write_enable_n, data_oe;
  int                    error_cnt = 0;
  int                    n_compared = 0;
  int                    lat, wl;
  // Clock and pin resolution: the host wins while it drives.
  always #5 ref_clk = ~ref_clk;
  // The small delay keeps the written word stable while both strobes rise at the write end.
  assign #1 data_in = data_oe ? data_out : ram_q;
  asr_host_ctrl dut (.ref_clk, .reset, .grade, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
    .rsp_valid, .rsp_rdata, .word_address_lines, .chip_enable_n, .output_enable_n, .write_enable_n,
    .data_in, .data_out, .data_oe);
  asr_sram_model ram (.addr(word_address_lines), .ce_n(chip_enable_n), .oe_n(output_enable_n),
    .we_n(write_enable_n), .bus(data_in), .q(ram_q));
  // Prints the verdict and ends the run.
  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Compares one value with its expectation.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One access: holds the request until the select falls, then times it.
  task automatic access(input logic w, input logic [ASR_ADDR_W-1:0] a, input logic [ASR_DATA_W-1:0] d);
    int n;
    n = 0;
    lat = 0;
    wl = 0;
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (chip_enable_n === 1'b0) req_valid = 0;
      if (write_enable_n === 1'b0) wl++;
      if (rsp_valid === 1'b1 && lat == 0) lat = n;
      if (rsp_valid === 1'b1) rd = rsp_rdata;
    end
    while (n < 40 && !(n > 2 && req_ready === 1'b1 && chip_enable_n === 1'b1));
    chk(n < 40, 1, "access hung");
  endtask
  // Idle pins after reset: deselected, not driving, ready.
  task automatic t_idle();
    chk({chip_enable_n, output_enable_n, write_enable_n, data_oe}, 8'h0e, "idle pins");
    chk({rsp_valid, req_ready}, 8'h01, "idle flags");
  endtask
  // Per grade: back-to-back writes at both ends, then reads of both, only the low one timed.
  task automatic t_grade(input asr_grade_t g);
    int nrd, np;
    grade = g;
    nrd = (ASR_T_READ_CYC_NS[g] + 9) / 10;
    np = (ASR_T_WR_PULSE_NS[g] + 9) / 10;
    access(1, 12'h000, 4'h5 + 4'(g));
    chk(wl, np, "write pulse");
    access(1, 12'hfff, 4'ha);
    chk(wl, np, "write pulse end");
    access(0, 12'h000, 4'h0);
    chk(lat, nrd + 1, "read latency");
    chk(rd, 4'h5 + 4'(g), "read low");
    access(0, 12'hfff, 4'h0);
    chk(rd, 4'ha, "read high");
  endtask
  // Overwrite one word, leave its neighbour alone.
  task automatic t_overwrite();
    access(1, 12'h5a4, 4'h9);
    access(1, 12'h5a5, 4'h3);
    access(1, 12'h5a5, 4'hc);
    access(0, 12'h5a5, 4'h0);
    chk(rd, 4'hc, "overwrite");
    access(0, 12'h5a4, 4'h0);
    chk(rd, 4'h9, "neighbour");
  endtask
  // Main sequence.
  initial
  begin
    repeat (8) @(negedge ref_clk);
    reset = 0;
    repeat (2) @(negedge ref_clk);
    t_idle();
    t_grade(ASR_GRADE_FAST);
    t_grade(ASR_GRADE_MID);
    t_grade(ASR_GRADE_SLOW);
    t_overwrite();
    summarize();
  end
  // Watchdog against a hang.
  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
